// ### design/pmcp_defines.svh
`ifndef PMCP_DEFINES_SVH
`define PMCP_DEFINES_SVH

// ==========================================================
// address spaces (byte addresses, 22 bits)
`define PMCP_ADDR_W          22
`define PMCP_ID_BASE         22'h200000
`define PMCP_ID_LAST         22'h200007
`define PMCP_CFG_BASE        22'h300000
`define PMCP_CFG_LAST        22'h3000ff
`define PMCP_DEVID_LO        22'h3ffffe
`define PMCP_DEVID_HI        22'h3fffff

// ==========================================================
// protection register offsets
`define PMCP_OFS_RDLOCK_BLK  22'h300008
`define PMCP_OFS_RDLOCK_BOOT 22'h300009
`define PMCP_OFS_WRLOCK_BLK  22'h30000a
`define PMCP_OFS_WRLOCK_BOOT 22'h30000b
`define PMCP_OFS_XRLOCK_BLK  22'h30000c
`define PMCP_OFS_XRLOCK_BOOT 22'h30000d

// ==========================================================
// field positions
`define PMCP_BIT_BLK0        0
`define PMCP_BIT_BLK1        1
`define PMCP_BIT_CFG_WR      5
`define PMCP_BIT_BOOT        6
`define PMCP_BIT_EE          7

// ==========================================================
// implemented bits; the four masks are also the unprogrammed (reset) values
`define PMCP_MASK_BLK        8'h03
`define PMCP_MASK_RD_BOOT    8'hc0
`define PMCP_MASK_WR_BOOT    8'he0
`define PMCP_MASK_XR_BOOT    8'h40
`define PMCP_SET_BOOT        8'h40
`define PMCP_KEEP_CFG_WR     8'h20

// ==========================================================
// region limits (last byte of each region)
`define PMCP_LG_BOOT1_END    22'h000fff
`define PMCP_LG_BOOT0_END    22'h0007ff
`define PMCP_LG_BLK0_END     22'h001fff
`define PMCP_LG_MEM_END      22'h003fff
`define PMCP_SM_BOOT1_END    22'h0007ff
`define PMCP_SM_BOOT0_END    22'h0003ff
`define PMCP_SM_BLK0_END     22'h000fff
`define PMCP_SM_MEM_END      22'h001fff

`endif

// ### design/pmcp_pkg.sv
package pmcp_pkg;

    // gray order along the address map
    typedef enum logic [1:0]
    {
        PMCP_RGN_BOOT = 2'h0,
        PMCP_RGN_BLK0 = 2'h1,
        PMCP_RGN_BLK1 = 2'h3,
        PMCP_RGN_NONE = 2'h2
    } pmcp_region_type;

endpackage

// ### design/pmcp_region_decoder.sv
`timescale 1ns/1ps
`include "pmcp_defines.svh"

module pmcp_region_decoder
    import pmcp_pkg::*;
(
    input  wire logic [21:0]     addr,
    input  wire logic            large_part,
    input  wire logic            boot_big,
    output pmcp_region_type      region
);

    logic [21:0] boot_end;
    logic [21:0] blk0_end;
    logic [21:0] mem_end;

    assign boot_end = large_part ? (boot_big ? `PMCP_LG_BOOT1_END : `PMCP_LG_BOOT0_END)
                                 : (boot_big ? `PMCP_SM_BOOT1_END : `PMCP_SM_BOOT0_END);
    assign blk0_end = large_part ? `PMCP_LG_BLK0_END : `PMCP_SM_BLK0_END;
    assign mem_end  = large_part ? `PMCP_LG_MEM_END : `PMCP_SM_MEM_END;

    assign region = (addr <= boot_end) ? PMCP_RGN_BOOT :
                    (addr <= blk0_end) ? PMCP_RGN_BLK0 :
                    (addr <= mem_end)  ? PMCP_RGN_BLK1 : PMCP_RGN_NONE;

endmodule

// ### design/pmcp_code_protect.sv
`timescale 1ns/1ps
`include "pmcp_defines.svh"

module pmcp_code_protect
    import pmcp_pkg::*;
#(
    parameter logic        LARGE_PART  = 1'b1,
    parameter logic [10:0] PART_CODE   = 11'h155,  // arbitrary value
    parameter logic [4:0]  SILICON_REV = 5'h01     // arbitrary value
)
(
    input  wire logic            clk,
    input  wire logic            nrst,
    input  wire logic            prog_mode_pin,
    input  wire logic            boot_region_size_select,
    input  wire logic            core_req,
    input  wire logic            core_we,
    input  wire logic            core_erase,
    input  wire logic            core_ee,
    input  wire logic [21:0]     core_addr,
    input  wire logic [21:0]     core_pc,
    input  wire logic [7:0]      core_wdata,
    output logic                 core_ack,
    output logic                 core_err,
    output logic [7:0]           core_rdata,
    input  wire logic            prog_req,
    input  wire logic            prog_we,
    input  wire logic            prog_erase,
    input  wire logic            prog_chip,
    input  wire logic            prog_ee,
    input  wire logic [21:0]     prog_addr,
    input  wire logic [7:0]      prog_wdata,
    output logic                 prog_ack,
    output logic                 prog_err,
    output logic [7:0]           prog_rdata,
    output logic                 mem_req,
    output logic                 mem_we,
    output logic                 mem_ee,
    output logic                 mem_erase,
    output logic                 mem_erase_chip,
    output logic [21:0]          mem_addr,
    output logic [7:0]           mem_wdata,
    input  wire logic [7:0]      mem_rdata
);

    localparam logic [7:0] LOCK_MASK [0:5] = '{`PMCP_MASK_BLK, `PMCP_MASK_RD_BOOT,
                                               `PMCP_MASK_BLK, `PMCP_MASK_WR_BOOT,
                                               `PMCP_MASK_BLK, `PMCP_MASK_XR_BOOT};

    // ==========================================================
    // pin synchronisers
    logic prog_meta_reg;
    logic prog_mode_reg;
    logic size_meta_reg;
    logic size_sel_reg;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            prog_meta_reg <= 1'b0;
            prog_mode_reg <= 1'b0;
            size_meta_reg <= 1'b1;
            size_sel_reg  <= 1'b1;
        end
        else
        begin
            prog_meta_reg <= prog_mode_pin;
            prog_mode_reg <= prog_meta_reg;
            size_meta_reg <= boot_region_size_select;
            size_sel_reg  <= size_meta_reg;
        end
    end

    // ==========================================================
    // request selection: the core is halted while in program mode
    logic        sel_prog;
    logic        take;
    logic        req_we;
    logic        req_erase;
    logic        req_ee;
    logic [21:0] req_addr;
    logic [7:0]  req_wdata;

    assign sel_prog  = prog_mode_reg;
    assign take      = sel_prog ? prog_req : core_req;
    assign req_we    = sel_prog ? prog_we : core_we;
    assign req_erase = sel_prog ? prog_erase : core_erase;
    assign req_ee    = sel_prog ? prog_ee : core_ee;
    assign req_addr  = sel_prog ? prog_addr : core_addr;
    assign req_wdata = sel_prog ? prog_wdata : core_wdata;

    // ==========================================================
    // region decode of target and of the fetching instruction
    pmcp_region_type rgn_t;
    pmcp_region_type rgn_pc;

    pmcp_region_decoder u_dec_target
    (
        .addr       (req_addr),
        .large_part (LARGE_PART),
        .boot_big   (size_sel_reg),
        .region     (rgn_t)
    );

    pmcp_region_decoder u_dec_fetch
    (
        .addr       (core_pc),
        .large_part (LARGE_PART),
        .boot_big   (size_sel_reg),
        .region     (rgn_pc)
    );

    // ==========================================================
    // lock bits, one per region: {blk1, blk0, boot}
    logic [7:0] cfg_reg  [0:5];
    logic [7:0] cfg_next [0:5];
    logic [2:0] ro_v;
    logic [2:0] wr_v;
    logic [2:0] xr_v;
    logic [1:0] t_idx;
    logic       t_valid;
    logic       ro_bit;
    logic       wr_bit;
    logic       xr_bit;
    logic       ee_ro;
    logic       ee_wr;
    logic       cfg_wr;

    assign ro_v    = {cfg_reg[0][`PMCP_BIT_BLK1], cfg_reg[0][`PMCP_BIT_BLK0],
                      cfg_reg[1][`PMCP_BIT_BOOT]};
    assign wr_v    = {cfg_reg[2][`PMCP_BIT_BLK1], cfg_reg[2][`PMCP_BIT_BLK0],
                      cfg_reg[3][`PMCP_BIT_BOOT]};
    assign xr_v    = {cfg_reg[4][`PMCP_BIT_BLK1], cfg_reg[4][`PMCP_BIT_BLK0],
                      cfg_reg[5][`PMCP_BIT_BOOT]};
    assign t_idx   = (rgn_t == PMCP_RGN_BOOT) ? 2'h0 : (rgn_t == PMCP_RGN_BLK0) ? 2'h1 : 2'h2;
    assign t_valid = (rgn_t != PMCP_RGN_NONE);
    assign ro_bit  = ro_v[t_idx];
    assign wr_bit  = wr_v[t_idx];
    assign xr_bit  = xr_v[t_idx];
    assign ee_ro   = cfg_reg[1][`PMCP_BIT_EE];
    assign ee_wr   = cfg_reg[3][`PMCP_BIT_EE];
    assign cfg_wr  = cfg_reg[3][`PMCP_BIT_CFG_WR];

    // ==========================================================
    // address space and access decision
    logic       sp_prog;
    logic       sp_id;
    logic       sp_lock;
    logic       sp_cfg;
    logic       sp_devid;
    logic       prog_ok;
    logic       ee_ok;
    logic       cfg_ok;
    logic       req_ok;
    logic       req_zero;
    logic       req_local;
    logic [2:0] lock_idx;
    logic [7:0] local_data;
    logic       mem_go;
    logic       lock_wr;
    logic       erase_go;

    assign sp_prog  = !req_ee && (req_addr < `PMCP_ID_BASE);
    assign sp_id    = !req_ee && (req_addr >= `PMCP_ID_BASE) && (req_addr <= `PMCP_ID_LAST);
    assign sp_lock  = !req_ee && (req_addr >= `PMCP_OFS_RDLOCK_BLK)
                              && (req_addr <= `PMCP_OFS_XRLOCK_BOOT);
    assign sp_cfg   = !req_ee && !sp_lock && (req_addr >= `PMCP_CFG_BASE)
                              && (req_addr <= `PMCP_CFG_LAST);
    assign sp_devid = !req_ee && ((req_addr == `PMCP_DEVID_LO) || (req_addr == `PMCP_DEVID_HI));

    // programmer is held off by readout lock, core by write lock
    assign prog_ok  = !t_valid ? !req_we : (sel_prog ? ro_bit : (!req_we || wr_bit));
    assign ee_ok    = req_we ? (ee_wr && (!sel_prog || ee_ro))
                             : (!sel_prog || ee_ro);
    assign cfg_ok   = !req_we || cfg_wr;

    // an erase is only honoured when it comes from the programmer
    assign req_ok   = req_erase ? sel_prog :
                      req_ee    ? ee_ok :
                      sp_prog   ? prog_ok :
                      sp_id     ? 1'b1 :
                      (sp_lock || sp_cfg) ? cfg_ok :
                      sp_devid  ? !req_we : 1'b0;

    // reads above memory and foreign cross-locked reads give zeros
    assign req_zero = !req_erase && !req_we && sp_prog &&
                      (!t_valid || (!sel_prog && !xr_bit && (rgn_pc != rgn_t)));
    assign req_local  = !req_erase && (sp_lock || sp_devid);
    assign lock_idx   = sp_lock ? req_addr[2:0] : 3'h0;
    assign local_data = !sp_devid ? cfg_reg[lock_idx] :
                        req_addr[0] ? PART_CODE[10:3] : {PART_CODE[2:0], SILICON_REV};
    assign mem_go   = take && req_ok && !req_local && !req_zero && !req_erase;
    assign lock_wr  = take && req_ok && sp_lock && req_we && !req_erase;
    assign erase_go = take && req_erase && sel_prog;

    // ==========================================================
    // protection bits: clear-only by write, set only by erase
    always_comb
    begin
        logic [7:0] set_v;
        logic [7:0] keep_v;
        set_v  = 8'h00;
        keep_v = 8'h00;
        for (int i = 0; i < 6; i++)
        begin
            if (!erase_go)
                set_v = 8'h00;
            else if (prog_chip)
                set_v = LOCK_MASK[i];
            else if (i % 2 == 1)
                set_v = (rgn_t == PMCP_RGN_BOOT) ? `PMCP_SET_BOOT : 8'h00;
            else
                set_v = {6'h00, rgn_t == PMCP_RGN_BLK1, rgn_t == PMCP_RGN_BLK0};
            // core cannot touch the config write lock
            keep_v = (!sel_prog && i == 3) ? `PMCP_KEEP_CFG_WR : 8'h00;
            if (lock_wr && lock_idx == 3'(i))
                cfg_next[i] = cfg_reg[i] & (req_wdata | keep_v);
            else
                cfg_next[i] = cfg_reg[i] | set_v;
        end
    end

    // reset stands in for the unprogrammed state
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 6; i++)
        begin
            if (!nrst)
                cfg_reg[i] <= LOCK_MASK[i];
            else
                cfg_reg[i] <= cfg_next[i];
        end
    end

    // ==========================================================
    // two-stage answer: memory cycle, then acknowledge
    logic       s1_valid_reg;
    logic       s1_prog_reg;
    logic       s1_ok_reg;
    logic       s1_rd_mem_reg;
    logic [7:0] s1_data_reg;
    logic [7:0] rdata_reg;
    logic       err_reg;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s1_valid_reg   <= 1'b0;
            s1_prog_reg    <= 1'b0;
            s1_ok_reg      <= 1'b0;
            s1_rd_mem_reg  <= 1'b0;
            s1_data_reg    <= 8'h00;
            mem_req        <= 1'b0;
            mem_we         <= 1'b0;
            mem_ee         <= 1'b0;
            mem_erase      <= 1'b0;
            mem_erase_chip <= 1'b0;
            mem_addr       <= 22'h000000;
            mem_wdata      <= 8'h00;
        end
        else
        begin
            s1_valid_reg   <= take;
            s1_prog_reg    <= sel_prog;
            s1_ok_reg      <= req_ok;
            s1_rd_mem_reg  <= mem_go && !req_we;
            s1_data_reg    <= (req_local && req_ok && !req_we) ? local_data : 8'h00;
            mem_req        <= mem_go;
            mem_we         <= req_we;
            mem_ee         <= req_ee;
            mem_erase      <= erase_go;
            mem_erase_chip <= erase_go && prog_chip;
            mem_addr       <= req_addr;
            mem_wdata      <= req_wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            core_ack  <= 1'b0;
            prog_ack  <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= 8'h00;
        end
        else
        begin
            core_ack  <= s1_valid_reg && !s1_prog_reg;
            prog_ack  <= s1_valid_reg && s1_prog_reg;
            err_reg   <= s1_valid_reg && !s1_ok_reg;
            rdata_reg <= s1_rd_mem_reg ? mem_rdata : s1_data_reg;
        end
    end

    assign core_err   = err_reg;
    assign prog_err   = err_reg;
    assign core_rdata = rdata_reg;
    assign prog_rdata = rdata_reg;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    logic [47:0] cfg_flat;
    assign cfg_flat = {cfg_reg[5], cfg_reg[4], cfg_reg[3], cfg_reg[2], cfg_reg[1], cfg_reg[0]};

    a_core_write_lock: assert property (
        take && !sel_prog && req_we && !req_erase && sp_prog && t_valid && !wr_bit
        |-> ##1 !mem_req ##1 (core_ack && core_err))
        else $error("write into write-locked region not refused");

    a_cross_read_zero: assert property (
        take && !sel_prog && !req_we && !req_erase && sp_prog && t_valid && !xr_bit
        && (rgn_pc != rgn_t) |-> ##2 (core_ack && !core_err && core_rdata == 8'h00))
        else $error("foreign read of cross-locked region not zero");

    a_own_read_pass: assert property (
        take && !sel_prog && !req_we && !req_erase && sp_prog && t_valid
        && (rgn_pc == rgn_t) |-> ##1 (mem_req && !mem_we) ##1 (core_ack && !core_err))
        else $error("own-region read not passed to memory");

    a_readout_core_free: assert property (
        take && !sel_prog && !req_we && !req_erase && sp_prog && t_valid && !ro_bit
        && xr_bit |-> ##1 mem_req)
        else $error("readout lock restricted the core");

    a_readout_prog_block: assert property (
        take && sel_prog && !req_erase && sp_prog && t_valid && !ro_bit
        |-> ##1 !mem_req ##1 (prog_ack && prog_err))
        else $error("programmer reached readout-locked region");

    a_bits_only_clear: assert property (
        |(cfg_flat & ~$past(cfg_flat)) |-> $past(erase_go))
        else $error("protection bit set without erase");

    a_core_erase_refused: assert property (
        take && !sel_prog && req_erase |-> ##1 !mem_erase ##1 (core_ack && core_err))
        else $error("core erase accepted");

    a_ee_write_lock: assert property (
        take && req_ee && req_we && !req_erase && !ee_wr |-> ##1 !mem_req ##1 err_reg)
        else $error("eeprom write passed under write lock");

    a_ee_prog_lock: assert property (
        take && sel_prog && req_ee && !req_erase && !ee_ro |-> ##1 !mem_req ##1 prog_err)
        else $error("programmer reached readout-locked eeprom");

    a_ee_core_read: assert property (
        take && !sel_prog && req_ee && !req_we && !req_erase
        |-> ##1 (mem_req && mem_ee) ##1 (core_ack && !core_err))
        else $error("core eeprom read refused");

    a_cfg_lock_core: assert property (
        take && !sel_prog && lock_wr |=> $stable(cfg_reg[3][`PMCP_BIT_CFG_WR]))
        else $error("core changed config write lock");

    a_cfg_write_block: assert property (
        take && req_we && !req_erase && (sp_cfg || sp_lock) && !cfg_wr
        |-> ##1 !mem_req ##1 err_reg)
        else $error("config write passed under config write lock");

    a_id_readable: assert property (
        take && sp_id && !req_we && !req_erase |-> ##1 mem_req ##1 !err_reg)
        else $error("user id read refused");

    c_cross_zero: cover property (
        take && !sel_prog && req_zero && t_valid ##2 core_ack);
    c_prog_erase: cover property (erase_go && !prog_chip ##1 mem_erase);
    c_lock_clear: cover property (lock_wr && sel_prog ##1 (cfg_flat != $past(cfg_flat)));
    c_back_to_back: cover property (take ##1 take ##1 take);

endmodule

// ### bench/pmcp_mem_model.sv
`timescale 1ns/1ps

// ==========================================================
// flash / eeprom array behind the protection block
module pmcp_mem_model
(
    input  wire logic            clk,
    input  wire logic            mem_req,
    input  wire logic            mem_we,
    input  wire logic            mem_ee,
    input  wire logic            mem_erase,
    input  wire logic            mem_erase_chip,
    input  wire logic [21:0]     mem_addr,
    input  wire logic [7:0]      mem_wdata,
    output logic      [7:0]      mem_rdata
);
    logic [7:0] store [int];
    logic [7:0] last_reg = 8'h00;
    logic [7:0] rd_data;
    int         k;

    // unwritten cells hold an address-derived pattern
    always @*
    begin
        k = {9'h000, mem_ee, mem_addr};
        rd_data = store.exists(k) ? store[k] : (mem_addr[7:0] ^ 8'h5a);
        // outside a read the bus toggles, never a stale copy
        mem_rdata = (mem_req && !mem_we) ? rd_data : ~last_reg;
    end

    always @(posedge clk)
    begin
        if (mem_req && mem_we)
            store[k] = mem_wdata;
        if (mem_erase && mem_erase_chip)
            store.delete();
        last_reg <= mem_rdata;
    end
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps

module testbench;
    typedef struct packed {logic side; logic err; logic [7:0] rd;} pmcp_exp_type;
    localparam logic [10:0] CODE = 11'h155;  // arbitrary value
    localparam logic [4:0]  REV  = 5'h01;    // arbitrary value
    // flags: prog, write, erase, chip, eeprom
    localparam logic [4:0] CR = 5'h00, CW = 5'h08, CRE = 5'h01, CWE = 5'h09, CER = 5'h04;
    localparam logic [4:0] PR = 5'h10, PW = 5'h18, PRE = 5'h11, PWE = 5'h19;
    localparam logic [4:0] PBE = 5'h14, PCE = 5'h16;
    localparam logic [7:0] RST_V [6] = '{8'h03, 8'hc0, 8'h03, 8'he0, 8'h03, 8'h40};

    logic clk = 1'b0, nrst, prog_mode_pin, boot_region_size_select;
    logic core_req, core_we, core_erase, core_ee, core_ack, core_err;
    logic prog_req, prog_we, prog_erase, prog_chip, prog_ee, prog_ack, prog_err;
    logic mem_req, mem_we, mem_ee, mem_erase, mem_erase_chip;
    logic [21:0] core_addr, core_pc, prog_addr, mem_addr;
    logic [7:0]  core_wdata, core_rdata, prog_wdata, prog_rdata, mem_wdata, mem_rdata;
    pmcp_exp_type expq [$];
    pmcp_exp_type e;
    logic [7:0]   shadow [int];
    logic [21:0]  ra;
    logic [7:0]   rd;
    int           num_errors = 0, n_checks = 0;

    always #2 clk = ~clk;

    pmcp_code_protect #(.LARGE_PART(1'b1), .PART_CODE(CODE), .SILICON_REV(REV)) dut
    (
        .clk(clk), .nrst(nrst), .prog_mode_pin(prog_mode_pin),
        .boot_region_size_select(boot_region_size_select),
        .core_req(core_req), .core_we(core_we), .core_erase(core_erase), .core_ee(core_ee),
        .core_addr(core_addr), .core_pc(core_pc), .core_wdata(core_wdata),
        .core_ack(core_ack), .core_err(core_err), .core_rdata(core_rdata),
        .prog_req(prog_req), .prog_we(prog_we), .prog_erase(prog_erase), .prog_chip(prog_chip),
        .prog_ee(prog_ee), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
        .prog_ack(prog_ack), .prog_err(prog_err), .prog_rdata(prog_rdata),
        .mem_req(mem_req), .mem_we(mem_we), .mem_ee(mem_ee), .mem_erase(mem_erase),
        .mem_erase_chip(mem_erase_chip), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata)
    );

    pmcp_mem_model mem
    (
        .clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_ee(mem_ee),
        .mem_erase(mem_erase), .mem_erase_chip(mem_erase_chip), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
    );

    // ==========================================================
    // comparisons and closing
    task automatic fail(input string msg);
        num_errors++;
        $display("MISMATCH at %0t: %s", $time, msg);
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp)
            fail($sformatf("%s got %b want %b", what, got, exp));
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp)
            fail($sformatf("%s got %h want %h", what, got, exp));
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================================
    // drivers
    function automatic logic [7:0] exp_mem(input logic ee, input logic [21:0] a);
        int k;
        k = {9'h000, ee, a};
        return shadow.exists(k) ? shadow[k] : (a[7:0] ^ 8'h5a);
    endfunction

    task automatic op(input logic [4:0] f, input logic [21:0] a, input logic [21:0] pc,
                      input logic [7:0] d, input logic xe, input logic [7:0] xr);
        @(posedge clk);
        #1;
        {prog_req, prog_we, prog_erase, prog_chip, prog_ee} = f[4] ? {1'b1, f[3:0]} : 5'h00;
        {core_req, core_we, core_erase, core_ee} = f[4] ? 4'h0 : {1'b1, f[3], f[2], f[0]};
        core_addr = a;
        prog_addr = a;
        core_pc = pc;
        core_wdata = d;
        prog_wdata = d;
        expq.push_back('{f[4], xe, xr});
        if (f[3] && !xe)
            shadow[{9'h000, f[0], a}] = d;
    endtask

    // release requests and let every answer land, bounded
    task automatic idle();
        @(posedge clk);
        #1;
        core_req = 1'b0;
        prog_req = 1'b0;
        for (int i = 0; i < 8 && expq.size() != 0; i++)
            @(posedge clk);
        #1;
    endtask

    // answers are looked at mid-cycle, well clear of the edge that launches them
    always @(negedge clk)
    begin
        if (core_ack === 1'b1 || prog_ack === 1'b1)
        begin
            if (expq.size() == 0)
                fail("answer with nothing pending");
            else
            begin
                e = expq.pop_front();
                chk_bit(prog_ack, e.side, "answering side");
                chk_bit(e.side ? prog_err : core_err, e.err, "refusal");
                chk_byte(e.side ? prog_rdata : core_rdata, e.rd, "read data");
            end
        end
    end

    initial
    begin
        #20000;
        fail("watchdog expired");
        wrap_up();
    end

    // ==========================================================
    // scenarios
    initial
    begin
        {nrst, prog_mode_pin, core_req, core_we, core_erase, core_ee} = 6'h00;
        {prog_req, prog_we, prog_erase, prog_chip, prog_ee} = 5'h00;
        {core_addr, core_pc, prog_addr, core_wdata, prog_wdata} = '0;
        boot_region_size_select = 1'b1;
        void'($urandom(39));
        repeat (12) @(posedge clk);
        #1;
        nrst = 1'b1;
        for (int i = 0; i < 6; i++)
            op(CR, 22'h300008 + 22'(i), 0, 0, 0, RST_V[i]);
        op(CR, 22'h3ffffe, 0, 0, 0, {CODE[2:0], REV});
        op(CR, 22'h3fffff, 0, 0, 0, CODE[10:3]);
        op(CW, 22'h3ffffe, 0, 8'h00, 1, 0);
        op(CW, 22'h001234, 0, 8'h77, 0, 0);
        op(CR, 22'h001234, 0, 0, 0, 8'h77);
        op(CR, 22'h005000, 0, 0, 0, 0);
        op(CW, 22'h005000, 0, 8'h55, 1, 0);
        op(CW, 22'h200003, 0, 8'h3c, 0, 0);
        op(CR, 22'h200003, 0, 0, 0, 8'h3c);
        for (int i = 0; i < 4; i++)
        begin
            ra = 22'h002000 + 22'($urandom % 8192);
            rd = 8'($urandom);
            op(CW, ra, 0, rd, 0, 0);
            op(CR, ra, 0, 0, 0, rd);
        end
        op(CW, 22'h30000a, 0, 8'hfe, 0, 0);
        op(CW, 22'h30000a, 0, 8'hff, 0, 0);
        op(CR, 22'h30000a, 0, 0, 0, 8'h02);
        op(CW, 22'h001100, 0, 8'h11, 1, 0);
        op(CW, 22'h002100, 0, 8'h21, 0, 0);
        op(CW, 22'h000900, 0, 8'h09, 0, 0);
        op(CW, 22'h30000c, 0, 8'hfd, 0, 0);
        op(CR, 22'h002100, 22'h002000, 0, 0, 8'h21);
        op(CR, 22'h002100, 22'h000100, 0, 0, 0);
        op(CW, 22'h300008, 0, 8'hfe, 0, 0);
        op(CR, 22'h001200, 0, 0, 0, exp_mem(0, 22'h001200));
        op(CWE, 22'h000020, 0, 8'h42, 0, 0);
        op(CW, 22'h30000b, 0, 8'h5f, 0, 0);
        op(CR, 22'h30000b, 0, 0, 0, 8'h60);
        op(CWE, 22'h000020, 0, 8'h99, 1, 0);
        op(CRE, 22'h000020, 0, 0, 0, 8'h42);
        op(CER, 22'h001000, 0, 0, 1, 0);
        idle();
        // smaller boot region puts 0x900 into block 0, whose writes are locked
        boot_region_size_select = 1'b0;
        repeat (3) @(posedge clk);
        op(CW, 22'h000900, 0, 8'h0a, 1, 0);
        idle();
        boot_region_size_select = 1'b1;
        prog_mode_pin = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        core_req = 1'b1;
        core_we = 1'b0;
        op(PR, 22'h001200, 0, 0, 1, 0);
        op(PW, 22'h001200, 0, 8'h12, 1, 0);
        op(PR, 22'h002100, 0, 0, 0, 8'h21);
        op(PW, 22'h300009, 0, 8'h40, 0, 0);
        op(PRE, 22'h000020, 0, 0, 1, 0);
        op(PWE, 22'h000020, 0, 8'h01, 1, 0);
        op(PW, 22'h30000b, 0, 8'h40, 0, 0);
        op(PR, 22'h30000b, 0, 0, 0, 8'h40);
        op(PW, 22'h30000a, 0, 8'h00, 1, 0);
        op(PR, 22'h200003, 0, 0, 0, 8'h3c);
        op(PBE, 22'h001000, 0, 0, 0, 0);
        op(PR, 22'h300008, 0, 0, 0, 8'h03);
        op(PR, 22'h30000a, 0, 0, 0, 8'h03);
        op(PCE, 22'h000000, 0, 0, 0, 0);
        op(PR, 22'h300009, 0, 0, 0, 8'hc0);
        op(PR, 22'h30000b, 0, 0, 0, 8'he0);
        op(PR, 22'h30000c, 0, 0, 0, 8'h03);
        // chip erase must have reached the array: written cell back to blank pattern
        op(PR, 22'h002100, 0, 0, 0, 8'h5a);
        idle();
        core_req = 1'b0;
        prog_mode_pin = 1'b0;
        if (expq.size() != 0)
            fail("answers missing");
        wrap_up();
    end
endmodule
